// >>> lcc_bank_properties.sv
// Port assertions for the LED config bank
`timescale 1ns/100ps
`default_nettype none
module lcc_bank_chk
  import lcc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_refused_o,
  input wire logic normal_i,
  input wire logic standby_i,
  input wire logic [5:0] run_control_i,
  input wire logic [5:0] mode_i,
  input wire logic [7:0] green_level_o,
  input wire logic pwm_fast_select_o,
  input wire lcc_pump_t pump_gain_mode_o,
  input wire logic [11:0] step_ptr_o
);
  // Decoded strobes and red pointer access gate
  wire logic set_wr = reg_wr_i && reg_addr_i == 8'h08;
  wire logic red_rd = reg_rd_i && reg_addr_i == 8'h09;
  wire logic red_ok = run_control_i[5:4] == 2'b11 && normal_i && !standby_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_lvl; reg_wr_i && reg_addr_i == 8'h06 |=> green_level_o == $past(reg_wdata_i);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level");
  property p_top; reg_rd_i && reg_addr_i == 8'h08 |=> !reg_rdata_o[7]; endproperty
  a_top: assert property (p_top) else $error("top bit");
  property p_fast; set_wr |=> pwm_fast_select_o == $past(reg_wdata_i[6]); endproperty
  a_fast: assert property (p_fast) else $error("fast");
  property p_pump; set_wr |=> pump_gain_mode_o == $past(reg_wdata_i[4:3]); endproperty
  a_pump: assert property (p_pump) else $error("pump");
  property p_clr; $changed(mode_i[5:4]) |=> step_ptr_o[11:8] == 4'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_load; mode_i[5:4] == 2'b01 [*2] |-> step_ptr_o[11:8] == 4'h0; endproperty
  a_load: assert property (p_load) else $error("load");
  property p_ref; red_rd && !red_ok |=> reg_refused_o && reg_rdata_o == 8'h00; endproperty
  a_ref: assert property (p_ref) else $error("refuse");
  property p_rd; red_rd && red_ok |=> !reg_refused_o && reg_rdata_o[3:0] == $past(step_ptr_o[11:8]);
  endproperty
  a_rd: assert property (p_rd) else $error("ptr read");
  c_ref: cover property (reg_refused_o);
  c_set: cover property (set_wr);
  c_clr: cover property ($changed(mode_i));
endmodule : lcc_bank_chk
bind lcc_config_bank lcc_bank_chk u_chk (
  .ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .reg_refused_o(reg_refused_o),
  .normal_i(normal_i),
  .standby_i(standby_i),
  .run_control_i(run_control_i),
  .mode_i(mode_i),
  .green_level_o(green_level_o),
  .pwm_fast_select_o(pwm_fast_select_o),
  .pump_gain_mode_o(pump_gain_mode_o),
  .step_ptr_o(step_ptr_o)
);
`default_nettype wire

// >>> lcc_config_bank.sv
// LED channel level, settings and step pointer register bank
`timescale 1ns/100ps
`default_nettype none
`include "lcc_regs.svh"
module lcc_config_bank
  import lcc_pkg::*;
#(
  parameter int unsigned PWM_SLOW_CYCLES = `LCC_CLK_HZ / `LCC_PWM_SLOW_HZ,
  parameter int unsigned PWM_FAST_CYCLES = `LCC_CLK_HZ / `LCC_PWM_FAST_HZ
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i, // Byte address from serial front end
  input wire logic [7:0] reg_wdata_i, // Write byte
  input wire logic reg_wr_i, // Write strobe, one cycle
  input wire logic reg_rd_i, // Read strobe, one cycle
  output logic [7:0] reg_rdata_o, // Read byte, valid cycle after strobe
  output logic reg_refused_o, // Access refused, pulse with read data
  input wire logic standby_i, // Device in standby
  input wire logic normal_i, // Device in normal operation
  input wire logic [5:0] run_control_i, // Run control per channel, red at [5:4]
  input wire logic [5:0] mode_i, // Operating mode per channel, red at [5:4]
  input wire logic [2:0] eng_load_i, // Engine pointer update, red at [2]
  input wire logic [11:0] eng_ptr_i, // Engine pointer values, red at [11:8]
  output logic [7:0] green_level_o,
  output logic [7:0] blue_level_o,
  output logic pwm_tick_o, // One pulse per PWM period
  output logic pwm_fast_select_o,
  output logic power_save_on_o,
  output var lcc_pump_t pump_gain_mode_o, // Pump gain decode
  output logic red_supply_select_o,
  output var lcc_clk_src_t clock_source_o, // PWM clock source decode
  output logic clock_detect_on_o,
  output logic [11:0] step_ptr_o, // Pointers, red at [11:8]
  output logic step_ptr_live_o // Pointers effective, low in standby
);
  // Bank of plain and gated registers behind one byte access port; every
  // accepted write lands at its strobe edge unless a pointer clear wins, and every read answers one cycle later
  // Register storage
  logic [7:0] green_drive_level; // Green level code
  logic [7:0] blue_drive_level; // Blue level code
  logic [6:0] global_settings; // Settings without top bit
  // Write decode
  logic green_wr; // Write strobe hits green level
  logic blue_wr; // Write strobe hits blue level
  logic settings_wr; // Write strobe hits settings
  // PWM timing
  logic [31:0] pwm_count; // PWM period counter
  logic [31:0] pwm_limit; // Selected period length
  logic pwm_wrap; // Counter in last cycle of period
  // Step pointer access
  logic [2:0] ptr_hit; // Address selects channel pointer
  logic [2:0] ptr_open; // Channel allows pointer access
  logic [2:0] ptr_wr; // Accepted pointer write per channel
  logic [11:0] ptr_value; // Pointer values from channels
  logic ptr_rd_ok; // Addressed pointer may be read now
  // Read path
  logic [7:0] next_rdata; // Read mux
  logic next_refused; // Read refusal

  // Address decode for the plain registers
  assign green_wr = reg_wr_i && reg_addr_i == `LCC_ADDR_GREEN_LEVEL;
  assign blue_wr = reg_wr_i && reg_addr_i == `LCC_ADDR_BLUE_LEVEL;
  assign settings_wr = reg_wr_i && reg_addr_i == `LCC_ADDR_SETTINGS;

  // Green level register, plain 8-bit code, every code legal
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      green_drive_level <= `LCC_LEVEL_RESET;
    end else if (green_wr) begin
      green_drive_level <= reg_wdata_i;
    end
  end

  // Blue level register, same coding as green
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      blue_drive_level <= `LCC_LEVEL_RESET;
    end else if (blue_wr) begin
      blue_drive_level <= reg_wdata_i;
    end
  end

  // Settings register; top bit is not stored so a stray one does nothing
  // The host must keep that bit at zero; dropping it here means a careless
  // write still reads back exactly what the bank acts on
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      global_settings <= 7'(`LCC_SETTINGS_RESET);
    end else if (settings_wr) begin
      global_settings <= 7'(reg_wdata_i & `LCC_SETTINGS_MASK);
    end
  end

  // Settings decode, plain wires off the register
  assign pwm_fast_select_o = global_settings[`LCC_BIT_PWM_FAST];
  assign power_save_on_o = global_settings[`LCC_BIT_POWER_SAVE];
  assign pump_gain_mode_o = lcc_pump_t'(global_settings[`LCC_BIT_PUMP_HI:`LCC_BIT_PUMP_LO]);
  assign red_supply_select_o = global_settings[`LCC_BIT_RED_SUPPLY];

  // Clock source and detector enable from the detect/internal pair
  // Codes 01 and 11 both mean internal clock with detection off
  always_comb begin
    case ({global_settings[`LCC_BIT_CLK_DETECT], global_settings[`LCC_BIT_INT_CLK]})
      2'b00: begin
        clock_source_o = LCC_CLK_EXTERNAL;
        clock_detect_on_o = 1'b0;
      end
      2'b10: begin
        clock_source_o = LCC_CLK_AUTO;
        clock_detect_on_o = 1'b1;
      end
      default: begin
        clock_source_o = LCC_CLK_INTERNAL;
        clock_detect_on_o = 1'b0;
      end
    endcase
  end

  // PWM period length from fast select, in whole clock cycles
  assign pwm_limit = pwm_fast_select_o ? PWM_FAST_CYCLES : PWM_SLOW_CYCLES;
  // Last cycle of the current period
  assign pwm_wrap = pwm_count >= pwm_limit - 32'h1;

  // PWM period counter; restarts at the end of each period
  // A switch to the shorter period may leave the count past the new end,
  // so the compare is >= rather than ==
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pwm_count <= 32'h0;
    end else if (pwm_wrap) begin
      pwm_count <= 32'h0;
    end else begin
      pwm_count <= pwm_count + 32'h1;
    end
  end

  // PWM tick, one cycle at the start of each period, registered one cycle after the wrap
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pwm_tick_o <= 1'b0;
    end else begin
      pwm_tick_o <= pwm_wrap;
    end
  end

  // Per-channel pointer access gate and pointer module
  // Channel 0 is blue at the highest pointer address, channel 2 is red
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_ch
      lcc_ptr_if link (); // Bank side to pointer side
      // Address match for this channel's pointer
      assign ptr_hit[ch] = reg_addr_i == (`LCC_ADDR_BLUE_PTR - 8'(ch));
      // Code 11b opens the pointer; hold 00b only parks the engine outside
      assign ptr_open[ch] = run_control_i[2*ch +: 2] == `LCC_RUN_ACCESS;
      // Write lands with the gate open, or in standby where writes are taken
      assign ptr_wr[ch] = reg_wr_i && ptr_hit[ch] && (ptr_open[ch] || standby_i);
      assign link.host_wr = ptr_wr[ch];
      assign link.host_data = reg_wdata_i[3:0];
      assign link.mode = mode_i[2*ch +: 2];
      assign link.eng_load = eng_load_i[ch];
      assign link.eng_data = eng_ptr_i[4*ch +: 4];
      assign ptr_value[4*ch +: 4] = link.value;
      // Pointer store with its own mode-change clear
      lcc_step_ptr u_ptr (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .link(link.ptr)
      );
    end
  endgenerate

  // Pointers go to the engines; a standby write only counts after startup
  assign step_ptr_o = ptr_value;
  assign step_ptr_live_o = !standby_i;

  // Pointer read needs the gate open, normal operation and no standby
  assign ptr_rd_ok = (ptr_hit & ptr_open) != 3'h0 && normal_i && !standby_i;

  // Read mux with pointer read restrictions
  // Unmapped addresses read zero and raise no refusal
  always_comb begin
    next_rdata = 8'h00;
    next_refused = 1'b0;
    case (reg_addr_i)
      `LCC_ADDR_GREEN_LEVEL: next_rdata = green_drive_level;
      `LCC_ADDR_BLUE_LEVEL: next_rdata = blue_drive_level;
      `LCC_ADDR_SETTINGS: next_rdata = {1'b0, global_settings};
      `LCC_ADDR_RED_PTR, `LCC_ADDR_GREEN_PTR, `LCC_ADDR_BLUE_PTR: begin
        if (ptr_rd_ok) begin
          // Upper nibble of a pointer reads zero
          next_rdata = {4'h0, ptr_value[4*(`LCC_ADDR_BLUE_PTR - reg_addr_i) +: 4]};
        end else begin
          // Refused: zero data and a refusal pulse
          next_refused = 1'b1;
        end
      end
      default: next_rdata = 8'h00; // Unmapped
    endcase
  end

  // Read data, holds until the next read
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // Refusal flag, one cycle alongside the read data
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      reg_refused_o <= 1'b0;
    end else begin
      reg_refused_o <= reg_rd_i && next_refused;
    end
  end

  // Level codes straight from the registers
  assign green_level_o = green_drive_level;
  assign blue_level_o = blue_drive_level;
endmodule : lcc_config_bank
`default_nettype wire

// >>> lcc_host_model.sv
// Host model driving single-byte register accesses
`timescale 1ns/100ps
`default_nettype none
module lcc_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial {addr_o, wdata_o, wr_o, rd_o} = '0;
  // Write pulse; settings top bit always sent as zero
  task wr(input logic [7:0] a, d);
    @(negedge clk_i);
    {addr_o, wdata_o, wr_o} = {a, (a == 8'h08 ? d & 8'h7f : d), 1'b1};
    @(negedge clk_i);
    {addr_o, wdata_o, wr_o} = {~a, ~d, 1'b0};
  endtask : wr
  // Read pulse; byte taken one cycle later
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    {addr_o, rd_o} = {a, 1'b1};
    @(negedge clk_i);
    {addr_o, rd_o, d} = {~a, 1'b0, rdata_i};
  endtask : rd
endmodule : lcc_host_model
`default_nettype wire

// >>> lcc_pkg.sv
// Types shared by the LED config bank modules
package lcc_pkg;
  typedef enum logic [1:0] {
    LCC_PUMP_OFF,
    LCC_PUMP_1X,
    LCC_PUMP_1P5X,
    LCC_PUMP_AUTO
  } lcc_pump_t;
  typedef enum logic [1:0] {
    LCC_CLK_EXTERNAL,
    LCC_CLK_INTERNAL,
    LCC_CLK_AUTO
  } lcc_clk_src_t;
  typedef logic [3:0] lcc_ptr_t;
endpackage : lcc_pkg

// >>> lcc_ptr_if.sv
// Per-channel step pointer link between bank and pointer module
`timescale 1ns/100ps
`default_nettype none
interface lcc_ptr_if;
  import lcc_pkg::*;
  logic host_wr; // Host write accepted this cycle
  lcc_ptr_t host_data; // Host write value
  logic [1:0] mode; // Channel operating mode
  logic eng_load; // Engine updates pointer
  lcc_ptr_t eng_data; // Engine pointer value
  lcc_ptr_t value; // Current pointer
  modport bank (output host_wr, host_data, mode, eng_load, eng_data, input value);
  modport ptr (input host_wr, host_data, mode, eng_load, eng_data, output value);
endinterface : lcc_ptr_if
`default_nettype wire

// >>> lcc_regs.svh
// Register offsets, field positions, reset values and timing for the LED config bank
`ifndef LCC_REGS_SVH
`define LCC_REGS_SVH
`define LCC_ADDR_GREEN_LEVEL 8'h06
`define LCC_ADDR_BLUE_LEVEL 8'h07
`define LCC_ADDR_SETTINGS 8'h08
`define LCC_ADDR_RED_PTR 8'h09
`define LCC_ADDR_GREEN_PTR 8'h0a
`define LCC_ADDR_BLUE_PTR 8'h0b
`define LCC_LEVEL_RESET 8'haf
`define LCC_SETTINGS_RESET 8'h00
`define LCC_PTR_RESET 4'h0
`define LCC_BIT_PWM_FAST 6
`define LCC_BIT_POWER_SAVE 5
`define LCC_BIT_PUMP_HI 4
`define LCC_BIT_PUMP_LO 3
`define LCC_BIT_RED_SUPPLY 2
`define LCC_BIT_CLK_DETECT 1
`define LCC_BIT_INT_CLK 0
`define LCC_SETTINGS_MASK 8'h7f
`define LCC_RUN_ACCESS 2'b11
`define LCC_MODE_LOAD 2'b01
`define LCC_CLK_HZ 200000000
`define LCC_PWM_SLOW_HZ 256
`define LCC_PWM_FAST_HZ 558
`endif

// >>> lcc_step_ptr.sv
// One channel step pointer with mode-change clear
`timescale 1ns/100ps
`default_nettype none
`include "lcc_regs.svh"
module lcc_step_ptr
  import lcc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  lcc_ptr_if.ptr link
);
  logic [1:0] mode_q; // Mode seen last cycle
  lcc_ptr_t value; // Pointer store

  // Remember previous mode to spot changes; it follows the mode through
  // reset as well, so the first edge after release sees no false change
  // that would drop a pointer write landing there
  always_ff @(posedge ref_clk_i) begin
    mode_q <= link.mode;
  end

  // Pointer update, clears win over writes
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      value <= `LCC_PTR_RESET;
    end else if (link.mode != mode_q) begin
      value <= `LCC_PTR_RESET;
    end else if (link.mode == `LCC_MODE_LOAD) begin
      value <= `LCC_PTR_RESET;
    end else if (link.host_wr) begin
      value <= link.host_data;
    end else if (link.eng_load) begin
      value <= link.eng_data;
    end
  end

  assign link.value = value;
endmodule : lcc_step_ptr
`default_nettype wire

// >>> tb.sv
// Random and corner tests of the LED config bank
`timescale 1ns/100ps
`default_nettype none
module tb;
  import lcc_pkg::*;
  logic ref_clk_i = 0, sys_rst_i = 1, standby_i = 0, normal_i = 1, reg_wr_i, reg_rd_i;
  logic reg_refused_o, pwm_tick_o, pwm_fast_select_o, power_save_on_o, red_supply_select_o;
  logic clock_detect_on_o, step_ptr_live_o;
  logic [2:0] eng_load_i = '0;
  logic [11:0] eng_ptr_i = '0, step_ptr_o;
  logic [5:0] run_control_i = 6'h3f, mode_i = 6'h2a;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, green_level_o, blue_level_o, rv, d, a;
  lcc_pump_t pump_gain_mode_o;
  lcc_clk_src_t clock_source_o;
  int num_errors = 0, checks = 0, n;
  always #2.5 ref_clk_i = ~ref_clk_i;
  lcc_host_model u_host (.clk_i(ref_clk_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
    .wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i));
  lcc_config_bank #(.PWM_SLOW_CYCLES(20), .PWM_FAST_CYCLES(8)) u_dut (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_refused_o(reg_refused_o), .standby_i(standby_i),
    .normal_i(normal_i), .run_control_i(run_control_i), .mode_i(mode_i),
    .eng_load_i(eng_load_i), .eng_ptr_i(eng_ptr_i), .green_level_o(green_level_o),
    .blue_level_o(blue_level_o), .pwm_tick_o(pwm_tick_o),
    .pwm_fast_select_o(pwm_fast_select_o), .power_save_on_o(power_save_on_o),
    .pump_gain_mode_o(pump_gain_mode_o), .red_supply_select_o(red_supply_select_o),
    .clock_source_o(clock_source_o), .clock_detect_on_o(clock_detect_on_o),
    .step_ptr_o(step_ptr_o), .step_ptr_live_o(step_ptr_live_o));
  // Compare and count
  task automatic chk(input string s, input logic [15:0] g, e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask : chk
  // Expected clock source from the bit pair
  function automatic lcc_clk_src_t exp_src(input logic [1:0] b);
    return b == 2'b00 ? LCC_CLK_EXTERNAL : b == 2'b10 ? LCC_CLK_AUTO : LCC_CLK_INTERNAL;
  endfunction : exp_src
  // Third tick interval measured, the second full one
  task automatic per(input int e);
    repeat (3) begin
      n = 0;
      do begin
        @(negedge ref_clk_i);
        n++;
      end while (!pwm_tick_o && n < 99);
    end
    chk("pwm", n, e);
  endtask : per
  task stop_test;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  initial begin
    #50000;
    num_errors++;
    stop_test;
  end
  initial begin
    void'($urandom(58));
    repeat (10) @(negedge ref_clk_i);
    sys_rst_i = 0;
    chk("ptr0", step_ptr_o, 12'h0);
    for (int i = 5; i < 10; i++) begin
      u_host.rd(8'(i), d);
      chk("reset", d, (i == 6 || i == 7) ? 8'haf : 8'h00);
    end
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      rv = i == 0 ? 8'hff : 8'($urandom);
      a = 8'h06 + 8'(i % 2);
      u_host.wr(a, rv);
      u_host.rd(a, d);
      chk("level", {(i % 2 ? blue_level_o : green_level_o), d}, {rv, rv});
    end
    $display("level test done");
    for (int k = 0; k < 8; k++) begin
      rv = k < 4 ? 8'(k * 9) : 8'($urandom) & 8'h7f;
      u_host.wr(8'h08, rv);
      u_host.rd(8'h08, d);
      chk("set", d, rv);
      chk("bits", {pwm_fast_select_o, power_save_on_o, pump_gain_mode_o,
        red_supply_select_o}, rv[6:2]);
      chk("src", {clock_detect_on_o, clock_source_o}, {rv[1:0] == 2'b10, exp_src(rv[1:0])});
    end
    u_host.wr(8'h08, 8'h40);
    per(8);
    u_host.wr(8'h08, 8'h00);
    per(20);
    $display("settings test done");
    for (int c = 0; c < 3; c++) begin
      rv = 8'($urandom);
      u_host.wr(8'h09 + 8'(c), rv);
      u_host.rd(8'h09 + 8'(c), d);
      chk("ptr", {step_ptr_o[8 - 4 * c +: 4], d}, {rv[3:0], 4'h0, rv[3:0]});
    end
    u_host.wr(8'h09, 8'h0c);
    run_control_i = 6'h0f;
    u_host.wr(8'h09, 8'h03);
    u_host.rd(8'h09, d);
    chk("gate", {reg_refused_o, d, step_ptr_o[11:8]}, {1'b1, 8'h00, 4'hc});
    run_control_i = 6'h3f;
    standby_i = 1;
    u_host.wr(8'h0a, 8'h09);
    u_host.rd(8'h0a, d);
    chk("stby", {step_ptr_live_o, reg_refused_o, d, step_ptr_o[7:4]}, 14'h1009);
    standby_i = 0;
    mode_i = 6'h3a;
    @(negedge ref_clk_i);
    chk("mode", step_ptr_o[11:8], 4'h0);
    chk("live", step_ptr_live_o, 1'b1);
    u_host.wr(8'h09, 8'h07);
    mode_i = 6'h1a;
    u_host.wr(8'h09, 8'h05);
    chk("load", step_ptr_o[11:8], 4'h0);
    mode_i = 6'h2a;
    eng_ptr_i = 12'ha00;
    @(negedge ref_clk_i);
    eng_load_i = 3'h4;
    @(negedge ref_clk_i);
    eng_load_i = 3'h0;
    chk("eng", step_ptr_o[11:8], 4'ha);
    $display("pointer test done");
    stop_test;
  end
endmodule : tb
`default_nettype wire
